// File: rtl/srm_refresh_ctrl.sv
module srm_refresh_ctrl
  import srm_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire srm_cfg_s         cfg,
  input  wire logic             count_wr,
  input  wire logic [CNT_W-1:0] count_wdata,
  input  wire srm_req_s         bus_req,
  input  wire logic             bus_cycle_busy,
  input  wire logic             bus_released,
  input  wire logic             other_irq,
  output logic [CNT_W-1:0]      refresh_timer_count,
  output logic                  mode_write_done,
  output logic                  access_allowed,
  output logic                  banks_closed,
  output logic                  self_refresh_active,
  output logic                  refresh_pending,
  output logic                  interrupt_out_pin_n,
  output srm_sdram_s            sdram
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_PRE, ST_PWAIT, ST_REF, ST_LOCK, ST_SELF, ST_MRS_PRE, ST_MRS
  } srm_state_e;

  typedef struct packed {
    srm_state_e       state;
    logic [CNT_W-1:0] count;
    logic             pending;
    logic             irq_n;
    logic [MODE_W-1:0] mode;
    logic             area3;
    logic             mode_done;
    logic             closed;
    srm_sdram_s       out;
  } srm_ctrl_s;

  srm_ctrl_s  st_reg, st_next;
  logic       tick;
  logic       wait_load;
  logic [3:0] wait_count;
  logic       wait_busy;
  logic       auto_mode;
  logic       self_mode;
  logic       match;
  logic       win_hit;

  function automatic logic [3:0] lock_len(input srm_cfg_s c);
    return {2'h0, c.ras_time} + {2'h0, c.pc_wait} + 4'h1;
  endfunction

  function automatic logic [3:0] pc_len(input srm_cfg_s c);
    return {2'h0, c.pc_wait} + 4'h1;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  srm_tick u_tick (
    .clock (clock),
    .reset (reset),
    .sel   (cfg.clk_sel),
    .tick  (tick)
  );

  srm_wait u_wait (
    .clock (clock),
    .reset (reset),
    .load  (wait_load),
    .count (wait_count),
    .busy  (wait_busy)
  );

  //////////////////////////////////////////////////////////////////////////////
  assign auto_mode = cfg.enable && !cfg.mode_sel;
  assign self_mode = cfg.enable && cfg.mode_sel;
  assign match     = tick && (st_reg.count == cfg.time_const);
  assign win_hit   = bus_req.valid && bus_req.write && bus_req.byte_sz &&
                     (((bus_req.addr & WIN_MASK) == AREA2_BASE) || ((bus_req.addr & WIN_MASK) == AREA3_BASE));

  always_comb begin
    st_next         = st_reg;
    wait_load       = 1'b0;
    wait_count      = 4'h0;
    st_next.out.cmd = SRM_CMD_NOP;
    st_next.mode_done = 1'b0;
    st_next.closed  = 1'b0;

    if (count_wr) begin
      st_next.count = count_wdata;
    end else if (match) begin
      st_next.count = '0;
    end else if (tick) begin
      st_next.count = st_reg.count + CNT_W'(1);
    end

    // a second match just overwrites the single pending flag
    if (match && auto_mode) begin
      st_next.pending = 1'b1;
      st_next.irq_n   = 1'b0;
    end else if (!st_reg.pending && !other_irq) begin
      // pin low only while some request still waits
      st_next.irq_n   = 1'b1;
    end

    case (st_reg.state)
      ST_IDLE: begin
        // runs regardless of sleep or manual reset: nothing here gates on them
        if (self_mode) begin
          st_next.state       = ST_SELF;
          st_next.out.cmd     = SRM_CMD_SELF;
          st_next.out.cke     = 1'b0;
          st_next.pending     = 1'b0;
        end else if (st_reg.pending && auto_mode && !bus_cycle_busy && !bus_released && !wait_busy) begin
          st_next.state   = ST_PRE;
          st_next.out.cmd = SRM_CMD_PRECHARGE_ALL_BANKS_CMD;
          st_next.pending = match;
          st_next.irq_n   = other_irq ? st_reg.irq_n : !match;
          wait_load       = 1'b1;
          wait_count      = pc_len(cfg);
        end else if (win_hit && !bus_cycle_busy && !bus_released && !wait_busy) begin
          st_next.state   = ST_MRS_PRE;
          st_next.out.cmd = SRM_CMD_PRECHARGE_ALL_BANKS_CMD;
          st_next.mode    = bus_req.addr[MODE_W-1:0];
          st_next.area3   = (bus_req.addr & WIN_MASK) == AREA3_BASE;
        end
      end
      ST_PRE: begin
        st_next.state = ST_PWAIT;
      end
      ST_PWAIT: begin
        if (!wait_busy) begin
          st_next.state   = ST_LOCK;
          st_next.out.cmd = SRM_CMD_REF;
          wait_load       = 1'b1;
          wait_count      = lock_len(cfg);
        end
      end
      ST_LOCK: begin
        if (!wait_busy) begin
          st_next.state  = ST_IDLE;
          st_next.closed = 1'b1;
        end
      end
      ST_SELF: begin
        st_next.out.cke = 1'b0;
        st_next.count   = st_reg.count;
        st_next.pending = 1'b0;
        if (!cfg.mode_sel) begin
          st_next.state   = ST_IDLE;
          st_next.out.cmd = SRM_CMD_SELF_EXIT;
          st_next.out.cke = 1'b1;
          st_next.closed  = 1'b1;
          wait_load       = 1'b1;
          wait_count      = pc_len(cfg);
        end
      end
      ST_MRS_PRE: begin
        st_next.state        = ST_MRS;
        st_next.out.cmd      = SRM_CMD_MRS;
        st_next.out.addr     = {MODE_HI_BITS, st_reg.mode[8:2], 2'h0};
        st_next.out.area3    = st_reg.area3;
      end
      ST_MRS: begin
        st_next.state     = ST_IDLE;
        st_next.mode_done = 1'b1;
      end
      default: begin
        st_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg           <= '0;
      st_reg.state     <= ST_IDLE;
      st_reg.irq_n     <= 1'b1;
      st_reg.out.cke   <= 1'b1;
      st_reg.out.cmd   <= SRM_CMD_NOP;
    end else begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  assign refresh_timer_count = st_reg.count;
  assign mode_write_done     = st_reg.mode_done;
  assign banks_closed        = st_reg.closed;
  assign self_refresh_active = st_reg.state == ST_SELF;
  assign refresh_pending     = st_reg.pending;
  assign interrupt_out_pin_n = st_reg.irq_n;
  assign sdram               = st_reg.out;
  // no ordinary access while refreshing, self-refreshing or locked out
  assign access_allowed      = (st_reg.state == ST_IDLE) && !wait_busy && !self_mode;

  //////////////////////////////////////////////////////////////////////////////
  sequence s_mrs_pre;
    st_reg.state == ST_MRS_PRE && sdram.cmd == SRM_CMD_PRECHARGE_ALL_BANKS_CMD;
  endsequence

  sequence s_mrs_cmd;
    sdram.cmd == SRM_CMD_MRS && sdram.addr[15:9] == MODE_HI_BITS;
  endsequence

  AST_SELF_CKE: assert property (@(posedge clock) disable iff (reset)
    self_refresh_active |-> !sdram.cke) else $error("clock enable high in self-refresh");
  AST_SELF_NO_ACCESS: assert property (@(posedge clock) disable iff (reset)
    self_refresh_active |-> !access_allowed) else $error("access allowed in self-refresh");
  AST_MATCH_CLEAR: assert property (@(posedge clock) disable iff (reset)
    (match && !count_wr) |=> refresh_timer_count == '0) else $error("count not cleared on match");
  AST_REQ_IRQ: assert property (@(posedge clock) disable iff (reset)
    (match && auto_mode && st_reg.state != ST_IDLE) |=> !interrupt_out_pin_n) else $error("no interrupt-out on request");
  AST_WAIT_BUS: assert property (@(posedge clock) disable iff (reset)
    (st_reg.state == ST_IDLE && (bus_cycle_busy || bus_released)) |=> sdram.cmd == SRM_CMD_NOP || self_refresh_active)
    else $error("refresh started during bus cycle");
  AST_REF_AFTER_PRE: assert property (@(posedge clock) disable iff (reset)
    (st_reg.state == ST_PRE) |-> ##[1:6] sdram.cmd == SRM_CMD_REF) else $error("refresh command missing");
  AST_LOCKOUT: assert property (@(posedge clock) disable iff (reset)
    sdram.cmd == SRM_CMD_REF |-> !access_allowed [*2]) else $error("command during lockout");
  AST_MRS_ORDER: assert property (@(posedge clock) disable iff (reset)
    s_mrs_pre |=> s_mrs_cmd) else $error("mode write not after precharge");
  AST_SELF_EXIT: assert property (@(posedge clock) disable iff (reset)
    (self_refresh_active && !cfg.mode_sel) |=> !self_refresh_active && sdram.cke) else $error("self-refresh not ended");
  AST_EXIT_BLOCK: assert property (@(posedge clock) disable iff (reset)
    sdram.cmd == SRM_CMD_SELF_EXIT |-> !access_allowed) else $error("command right after self-refresh exit");
  AST_IRQ_RELEASE: assert property (@(posedge clock) disable iff (reset)
    (st_reg.state == ST_PRE && !$past(other_irq) && !$past(match)) |-> interrupt_out_pin_n)
    else $error("interrupt-out not released at refresh start");
  AST_CLOSE_AFTER_LOCK: assert property (@(posedge clock) disable iff (reset)
    (st_reg.state == ST_LOCK && !wait_busy) |=> banks_closed) else $error("banks not closed after refresh");
endmodule

// File: rtl/srm_pkg.sv
package srm_pkg;
  localparam int          CNT_W         = 8;
  localparam logic [31:0] AREA2_BASE    = 32'hffffd000;
  localparam logic [31:0] AREA3_BASE    = 32'hffffe000;
  localparam logic [31:0] WIN_MASK      = 32'hfffff000;
  localparam int          MODE_W        = 12;
  localparam logic [6:0]  MODE_HI_BITS  = 7'h04;
  localparam logic [2:0]  CLK_SEL_OFF   = 3'h0;
  localparam logic [2:0]  PRESCALE_STOP = 3'h7;

  typedef enum logic [3:0] {
    SRM_CMD_NOP, SRM_CMD_PRECHARGE_ALL_BANKS_CMD, SRM_CMD_REF, SRM_CMD_SELF, SRM_CMD_SELF_EXIT, SRM_CMD_MRS
  } srm_cmd_e;

  typedef struct packed {
    logic             enable;
    logic             mode_sel;
    logic [2:0]       clk_sel;
    logic [1:0]       pc_wait;
    logic [1:0]       ras_time;
    logic [CNT_W-1:0] time_const;
  } srm_cfg_s;

  typedef struct packed {
    logic        valid;
    logic [31:0] addr;
    logic        byte_sz;
    logic        write;
  } srm_req_s;

  typedef struct packed {
    srm_cmd_e          cmd;
    logic [15:0]       addr;
    logic              area3;
    logic              cke;
  } srm_sdram_s;
endpackage

// File: rtl/srm_tick.sv
module srm_tick
  import srm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic [2:0] sel,
  output logic            tick
);
  typedef struct packed {
    logic [11:0] div;
    logic        tick;
  } srm_tick_s;
  srm_tick_s st_reg, st_next;

  // selector picks a power-of-four divider tap of the bus clock
  function automatic logic tap(input logic [11:0] d, input logic [2:0] s);
    logic [11:0] m;
    m = (12'h001 << {s, 1'b0}) - 12'h001;
    return (d & m) == m;
  endfunction

  always_comb begin
    st_next      = st_reg;
    st_next.div  = st_reg.div + 12'h001;
    st_next.tick = (sel != CLK_SEL_OFF) && (sel != PRESCALE_STOP) && tap(st_reg.div, sel - 3'h1);
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;
endmodule

// File: rtl/srm_wait.sv
module srm_wait
  import srm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       load,
  input  wire logic [3:0] count,
  output logic            busy
);
  typedef struct packed {
    logic [3:0] left;
  } srm_wait_s;
  srm_wait_s st_reg, st_next;

  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.left = count;
    end else if (st_reg.left != 4'h0) begin
      st_next.left = st_reg.left - 4'h1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign busy = st_reg.left != 4'h0;
endmodule

// File: bench/srm_sdram_model.sv
module srm_sdram_model
  import srm_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire srm_sdram_s sdram,
  output logic [15:0]     mode_reg,
  output logic            mode_area3,
  output logic [7:0]      ref_cnt
);
  timeunit 1ns;
  timeprecision 1ns;
  // commands are ignored while clock enable is low, as on a real part
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_reg   <= 16'h0000;
      mode_area3 <= 1'b0;
      ref_cnt    <= 8'h00;
    end else if (sdram.cke) begin
      if (sdram.cmd == SRM_CMD_MRS) begin
        mode_reg   <= sdram.addr;
        mode_area3 <= sdram.area3;
      end
      if (sdram.cmd == SRM_CMD_REF) begin
        ref_cnt <= ref_cnt + 8'h01;
      end
    end
  end
endmodule

// File: bench/tb_sdram_refresh_mode_set.sv
module tb_sdram_refresh_mode_set
  import srm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic             clock, reset, count_wr, bus_cycle_busy, bus_released, other_irq;
  srm_cfg_s         cfg;
  logic [CNT_W-1:0] count_wdata, refresh_timer_count;
  srm_req_s         bus_req;
  logic             mode_write_done, access_allowed, banks_closed, self_refresh_active;
  logic             refresh_pending, interrupt_out_pin_n, mode_area3;
  srm_sdram_s       sdram;
  logic [15:0]      mode_reg;
  logic [7:0]       ref_cnt;
  int               n_fail, num_checks, n;

  srm_refresh_ctrl i_srm_refresh_ctrl (.clock(clock), .reset(reset), .cfg(cfg), .count_wr(count_wr),
    .count_wdata(count_wdata), .bus_req(bus_req), .bus_cycle_busy(bus_cycle_busy),
    .bus_released(bus_released), .other_irq(other_irq), .refresh_timer_count(refresh_timer_count),
    .mode_write_done(mode_write_done), .access_allowed(access_allowed), .banks_closed(banks_closed),
    .self_refresh_active(self_refresh_active), .refresh_pending(refresh_pending),
    .interrupt_out_pin_n(interrupt_out_pin_n), .sdram(sdram));
  srm_sdram_model i_srm_sdram_model (.clock(clock), .reset(reset), .sdram(sdram), .mode_reg(mode_reg),
    .mode_area3(mode_area3), .ref_cnt(ref_cnt));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(logic [31:0] seen, logic [31:0] exp, string what);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic cyc(int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic hang(string what);
    n_fail++;
    $display("CHECK FAILED %0t wait ran out: %s", $time, what);
    wrap_up();
  endtask
  task automatic wait_cmd(srm_cmd_e c, int lim);
    n = 0;
    while (sdram.cmd !== c) begin
      if (n == lim) hang("command");
      cyc(1);
      n++;
    end
  endtask
  task automatic wait_hi(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v) begin
      if (n == lim) hang("level");
      cyc(1);
      n++;
    end
  endtask
  task automatic count_cmd(srm_cmd_e c, int k, output int hits);
    hits = 0;
    repeat (k) begin
      cyc(1);
      if (sdram.cmd === c) hits++;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic refresh_run(logic [7:0] tc, logic [1:0] pw, logic [1:0] ras);
    int busy_cmds, closed;
    logic [7:0] r;
    @(posedge clock);
    cfg <= '{1'b1, 1'b0, 3'h1, pw, ras, tc};
    cyc(1);
    wait_hi(refresh_pending, 1'b1, 300);
    check(interrupt_out_pin_n, 0, "irq on request");
    check(refresh_timer_count <= 1, 1, "count cleared");
    r = ref_cnt;
    wait_cmd(SRM_CMD_PRECHARGE_ALL_BANKS_CMD, 10);
    wait_cmd(SRM_CMD_REF, 10);
    check(n >= pw + 2 && n <= pw + 3, 1, "precharge to refresh gap");
    busy_cmds = 0;
    closed = 0;
    for (int i = 0; i < ras + pw + 4; i++) begin
      cyc(1);
      if (i < ras + pw && sdram.cmd !== SRM_CMD_NOP) busy_cmds++;
      if (banks_closed === 1'b1) closed++;
    end
    check(busy_cmds, 0, "lockout after refresh");
    check(closed, 1, "banks closed once");
    check(ref_cnt, r + 8'h01, "one refresh seen");
    check(interrupt_out_pin_n, 1, "irq released");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int hits;
    logic [11:0] x;
    reset = 1'b1;
    cfg = '0;
    count_wr = 1'b0;
    count_wdata = '0;
    bus_req = '0;
    bus_cycle_busy = 1'b0;
    bus_released = 1'b0;
    other_irq = 1'b0;
    repeat (12) @(posedge clock);
    reset <= 1'b0;
    void'($urandom(33));
    // timer stopped: written value must hold, then count on from it
    @(posedge clock);
    count_wr <= 1'b1;
    count_wdata <= 8'h0a;
    @(posedge clock);
    count_wr <= 1'b0;
    cyc(5);
    check(refresh_timer_count, 8'h0a, "count held");
    @(posedge clock);
    cfg <= '{1'b1, 1'b0, CLK_SEL_OFF, 2'h0, 2'h0, 8'hc8};
    cyc(2);
    check(refresh_timer_count, 8'h0a, "no count before select");
    @(posedge clock);
    cfg.clk_sel <= 3'h1;
    cyc(4);
    check(refresh_timer_count > 8'h0a && refresh_timer_count <= 8'h0f, 1, "count on");
    refresh_run(8'h14, 2'h1, 2'h2);
    for (int k = 0; k < 4; k++) refresh_run(8'($urandom_range(20, 80)), 2'($urandom_range(0, 3)),
      2'($urandom_range(0, 3)));
    $display("test auto refresh done");
    // refresh held off by a bus cycle, then by a released bus
    for (int i = 0; i < 2; i++) begin
      @(posedge clock);
      cfg <= '{1'b1, 1'b0, 3'h1, 2'h0, 2'h0, 8'h14};
      bus_cycle_busy <= (i == 0);
      bus_released <= (i == 1);
      other_irq <= (i == 1);
      count_cmd(SRM_CMD_PRECHARGE_ALL_BANKS_CMD, 45, hits);
      check(hits, 0, "deferred");
      // restart the count so no fresh match lands beside the start
      @(posedge clock);
      count_wr <= 1'b1;
      count_wdata <= 8'h00;
      @(posedge clock);
      count_wr <= 1'b0;
      bus_cycle_busy <= 1'b0;
      bus_released <= 1'b0;
      cyc(1);
      wait_cmd(SRM_CMD_PRECHARGE_ALL_BANKS_CMD, 6);
      wait_cmd(SRM_CMD_REF, 6);
      check(interrupt_out_pin_n, (i == 1) ? 0 : 1, "irq with other pending");
      count_cmd(SRM_CMD_PRECHARGE_ALL_BANKS_CMD, 6, hits);
      check(hits, 0, "no queued refresh");
      other_irq <= 1'b0;
    end
    $display("test deferral done");
    // entry order: enable off, count zero, then both bits
    @(posedge clock);
    cfg <= '{1'b0, 1'b0, 3'h1, 2'h2, 2'h1, 8'h1e};
    count_wr <= 1'b1;
    count_wdata <= 8'h00;
    @(posedge clock);
    count_wr <= 1'b0;
    cfg <= '{1'b1, 1'b1, 3'h1, 2'h2, 2'h1, 8'h1e};
    cyc(1);
    wait_hi(self_refresh_active, 1'b1, 10);
    count_cmd(SRM_CMD_REF, 60, hits);
    check({sdram.cke, access_allowed, 6'(hits)}, 0, "self refresh held");
    @(posedge clock);
    cfg.mode_sel <= 1'b0;
    cyc(1);
    wait_hi(self_refresh_active, 1'b0, 10);
    check({sdram.cke, access_allowed}, 2'b10, "exit blocks commands");
    wait_cmd(SRM_CMD_REF, 300);
    @(posedge clock);
    cfg.mode_sel <= 1'b1;
    cyc(1);
    wait_hi(self_refresh_active, 1'b1, 10);
    @(posedge clock);
    reset <= 1'b1;
    cfg <= '0;
    cyc(2);
    check({self_refresh_active, sdram.cke}, 2'b01, "power-on ends self refresh");
    @(posedge clock);
    reset <= 1'b0;
    repeat (2500) @(posedge clock);
    cfg <= '{1'b1, 1'b0, 3'h1, 2'h0, 2'h0, 8'h04};
    repeat (100) @(posedge clock);
    cfg <= '0;
    cyc(10);
    check(ref_cnt >= 8'h08 && ref_cnt < 8'h40, 1, "dummy refreshes");
    $display("test self refresh done");
    // mode register programming for latencies 1 to 3 in both areas
    for (int a = 0; a < 2; a++) for (int cl = 1; cl < 4; cl++) begin
      x = {4'h8, 2'(cl), 6'h00};
      @(posedge clock);
      bus_req <= '{1'b1, (a == 1 ? AREA3_BASE : AREA2_BASE) | {20'h0, x}, 1'b1, 1'b1};
      @(posedge clock);
      bus_req.valid <= 1'b0;
      #1;
      wait_cmd(SRM_CMD_PRECHARGE_ALL_BANKS_CMD, 4);
      wait_cmd(SRM_CMD_MRS, 3);
      check(n, 1, "mode command follows precharge");
      check(sdram.addr, {MODE_HI_BITS, x[8:2], 2'b00}, "mode address");
      wait_hi(mode_write_done, 1'b1, 3);
      check({mode_area3, mode_reg}, {a[0], MODE_HI_BITS, x[8:2], 2'b00}, "mode stored");
    end
    @(posedge clock);
    bus_req <= '{1'b1, AREA2_BASE | 32'h840, 1'b0, 1'b1};
    @(posedge clock);
    bus_req.valid <= 1'b0;
    count_cmd(SRM_CMD_PRECHARGE_ALL_BANKS_CMD, 6, hits);
    check(hits, 0, "word write ignored");
    $display("test mode write done");
    wrap_up();
  end
endmodule
